// ---- hw/urs_pkg.sv ----
// Package: register selection constants and carrier types for the serial register bank
package urs_pkg;

  // ----------------------------------------------------------------
  // Addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] URS_A_HOLD   = 3'h0;
  localparam logic [2:0] URS_A_INTEN  = 3'h1;
  localparam logic [2:0] URS_A_INTSRC = 3'h2;
  localparam logic [2:0] URS_A_LFMT   = 3'h3;
  localparam logic [2:0] URS_A_MCTL   = 3'h4;
  localparam logic [2:0] URS_A_LST    = 3'h5;
  localparam logic [2:0] URS_A_MST    = 3'h6;
  localparam logic [2:0] URS_A_SCR    = 3'h7;

  // ----------------------------------------------------------------
  // Field positions, masks, key and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] URS_LF_KEY      = 8'hbf;
  localparam int         URS_LF_DIV      = 7;
  localparam int         URS_MC_RDY_EN   = 2;
  localparam int         URS_MC_LOOP     = 4;
  localparam int         URS_MC_THR_EN   = 6;
  localparam int         URS_ENH_EN      = 4;
  localparam int         URS_FS_FIFO_EN  = 0;
  localparam int         URS_FS_RX_CLR   = 1;
  localparam int         URS_FS_TX_CLR   = 2;
  localparam int         URS_FS_DMA      = 3;
  localparam logic [7:0] URS_IE_ENH_MASK = 8'hf0;
  localparam logic [7:0] URS_MC_ENH_MASK = 8'he0;
  localparam logic [7:0] URS_RST_BYTE    = 8'h00;
  localparam logic [1:0] URS_RST_TRIG    = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    R_HOLD, R_INT_EN, R_INT_SRC, R_LINE_FMT, R_MODEM_CTL, R_LINE_ST, R_MODEM_ST,
    R_SCRATCH, R_DIV_LO, R_DIV_HI, R_ENH, R_RESUME1, R_RESUME2, R_PAUSE1,
    R_PAUSE2, R_THRESH, R_TRIG, R_READY
  } urs_reg_t;

  typedef struct packed {
    logic avail;
    logic overrun;
    logic parity_err;
    logic framing_err;
    logic brk;
    logic tx_hold_empty;
    logic tx_all_empty;
    logic fifo_err;
  } urs_line_in_t;

  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } urs_modem_t;

  typedef struct packed {
    logic       no_irq;
    logic [2:0] code;
    logic       pause_flag;
    logic       flow_flag;
  } urs_int_in_t;

  typedef struct packed {
    logic [15:0] divisor;
    logic [7:0]  line_format;
    logic [7:0]  interrupt_enables;
    logic [7:0]  modem_control_bits;
    logic [7:0]  enhanced_features;
    logic        fifo_en;
    logic        dma_mode;
    logic [1:0]  tx_trig;
    logic [1:0]  rx_trig;
    logic [7:0]  flow_thresholds;
    logic [7:0]  fifo_trigger_levels;
    logic [7:0]  resume_char_one;
    logic [7:0]  resume_char_two;
    logic [7:0]  pause_char_one;
    logic [7:0]  pause_char_two;
  } urs_cfg_t;

endpackage

// ---- hw/urs_top.sv ----
// Register selection and register bank for one serial channel
`timescale 1ns/1ps
// Functional notes
// - Non-FIFO mode: holding data readable one baud tick after status reports it.
// - FIFO mode: holding data already valid when status reports it.
// - Register chosen from three address lines plus gating bits.
// - Address 000, divisor access off: read received byte, write transmit byte.
// - Address 001 holds eight interrupt enables.
// - Read 010 gives interrupt source; bits 7:6 copy FIFO enable.
// - Write 010 goes to write-only FIFO setup fields.
// - Address 011 holds the line format fields.
// - Address 100 holds modem control bits.
// - Address 101 reads line state flags.
// - Address 110 reads modem change flags low, levels high.
// - Address 111 is a plain scratch byte.
// - Divisor access bit set: 000/001 reach divisor low/high bytes.
// - Key 0xBF: 010 enhanced features, 100-111 flow characters.
// - Enhanced features hold flow mode, enable, detect, auto RTS/CTS.
// - Thresholds and trigger levels reachable only with both gate bits set.
// - Ready status at 111 only with both selects low, enable, no loopback.
// - Modem control bit 7 write ignored unless enhanced enable set.
// - Enhanced-only bits change only with enhanced enable; flags read zero.
// - FIFO clear bits pulse a clear and return to zero alone.
module urs_top (
  // Clock and reset
  input  wire  logic                  sys_clk,
  input  wire  logic                  rst,
  // Host parallel bus
  input  wire  logic                  channel_a_select_n,
  input  wire  logic                  channel_b_select_n,
  input  wire  logic [2:0]            addr,
  input  wire  logic                  rd_n,
  input  wire  logic                  wr_n,
  input  wire  logic [7:0]            wdata,
  output logic       [7:0]            rdata,
  output logic                        rdata_oe,
  // Receive side
  input  wire  logic                  baud_tick,
  input  wire  logic                  rx_char_stb,
  input  wire  logic [7:0]            rx_char,
  input  wire  logic [7:0]            rx_head,
  output logic                        rx_pop,
  output logic                        rx_fifo_clr,
  // Transmit side
  output logic       [7:0]            tx_data,
  output logic                        tx_load,
  output logic                        tx_fifo_clr,
  // Status from the channel core
  input  wire  urs_pkg::urs_line_in_t line_in,
  input  wire  urs_pkg::urs_modem_t   modem_in,
  input  wire  urs_pkg::urs_int_in_t  int_in,
  input  wire  logic [3:0]            ready_in,
  // Configuration to the channel core
  output urs_pkg::urs_cfg_t           cfg
);

  // ----------------------------------------------------------------
  // Register selection
  // ----------------------------------------------------------------
  function automatic urs_pkg::urs_reg_t sel_reg(input logic [2:0] a, input logic [7:0] lf,
                                                 input logic enh, input logic [7:0] mc,
                                                 input logic both_sel);
    urs_pkg::urs_reg_t r;
    r = urs_pkg::R_SCRATCH;
    if (lf == urs_pkg::URS_LF_KEY && a == urs_pkg::URS_A_INTSRC) begin
      r = urs_pkg::R_ENH;
    end else if (lf == urs_pkg::URS_LF_KEY && a == urs_pkg::URS_A_MCTL) begin
      r = urs_pkg::R_RESUME1;
    end else if (lf == urs_pkg::URS_LF_KEY && a == urs_pkg::URS_A_LST) begin
      r = urs_pkg::R_RESUME2;
    end else if (lf == urs_pkg::URS_LF_KEY && a == urs_pkg::URS_A_MST) begin
      r = urs_pkg::R_PAUSE1;
    end else if (lf == urs_pkg::URS_LF_KEY && a == urs_pkg::URS_A_SCR) begin
      r = urs_pkg::R_PAUSE2;
    end else if (lf[urs_pkg::URS_LF_DIV] && a == urs_pkg::URS_A_HOLD) begin
      r = urs_pkg::R_DIV_LO;
    end else if (lf[urs_pkg::URS_LF_DIV] && a == urs_pkg::URS_A_INTEN) begin
      r = urs_pkg::R_DIV_HI;
    end else if (a == urs_pkg::URS_A_HOLD) begin
      r = urs_pkg::R_HOLD;
    end else if (a == urs_pkg::URS_A_INTEN) begin
      r = urs_pkg::R_INT_EN;
    end else if (a == urs_pkg::URS_A_INTSRC) begin
      r = urs_pkg::R_INT_SRC;
    end else if (a == urs_pkg::URS_A_LFMT) begin
      r = urs_pkg::R_LINE_FMT;
    end else if (a == urs_pkg::URS_A_MCTL) begin
      r = urs_pkg::R_MODEM_CTL;
    end else if (a == urs_pkg::URS_A_LST) begin
      r = urs_pkg::R_LINE_ST;
    end else if (a == urs_pkg::URS_A_MST && enh && mc[urs_pkg::URS_MC_THR_EN]) begin
      r = urs_pkg::R_THRESH;
    end else if (a == urs_pkg::URS_A_MST) begin
      r = urs_pkg::R_MODEM_ST;
    end else if (enh && mc[urs_pkg::URS_MC_THR_EN]) begin
      r = urs_pkg::R_TRIG;
    end else if (both_sel && mc[urs_pkg::URS_MC_RDY_EN] && !mc[urs_pkg::URS_MC_LOOP]) begin
      r = urs_pkg::R_READY;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]        lf_q, ie_q, mc_q, enh_q, scr_q, dlo_q, dhi_q;
  logic [7:0]        res1_q, res2_q, pau1_q, pau2_q, thr_q, trg_q;
  logic              fifo_en_q, dma_q;
  logic [1:0]        tx_trig_q, rx_trig_q;
  logic              wr_prev_n_q, rd_prev_n_q, rd_act_q;
  urs_pkg::urs_reg_t rd_reg_q;
  logic [7:0]        rdata_q, tx_data_q, hold_q, pend_q;
  logic              tx_load_q, rx_pop_q, rx_clr_q, tx_clr_q, pend_v_q;
  urs_pkg::urs_modem_t modem_q, delta_q;

  logic              enh_en, both_sel, wr_fire, rd_start, rd_end;
  urs_pkg::urs_reg_t cur_reg;
  logic [7:0]        rd_mux;

  assign enh_en   = enh_q[urs_pkg::URS_ENH_EN];
  assign both_sel = !channel_a_select_n && !channel_b_select_n;
  assign cur_reg  = sel_reg(addr, lf_q, enh_en, mc_q, both_sel);
  assign wr_fire  = !channel_a_select_n && !wr_n && wr_prev_n_q;
  assign rd_start = !channel_a_select_n && !rd_n && rd_prev_n_q;
  assign rd_end   = rd_act_q && rd_n;

  // ----------------------------------------------------------------
  // Strobe tracking
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_prev_n_q <= 1'b1;
      rd_prev_n_q <= 1'b1;
      rd_act_q    <= 1'b0;
      rd_reg_q    <= urs_pkg::R_SCRATCH;
    end else begin
      wr_prev_n_q <= wr_n;
      rd_prev_n_q <= rd_n;
      if (rd_start) begin
        rd_act_q <= 1'b1;
        rd_reg_q <= cur_reg;
      end else if (rd_n) begin
        rd_act_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lf_q      <= urs_pkg::URS_RST_BYTE;
      ie_q      <= urs_pkg::URS_RST_BYTE;
      mc_q      <= urs_pkg::URS_RST_BYTE;
      enh_q     <= urs_pkg::URS_RST_BYTE;
      scr_q     <= urs_pkg::URS_RST_BYTE;
      dlo_q     <= urs_pkg::URS_RST_BYTE;
      dhi_q     <= urs_pkg::URS_RST_BYTE;
      res1_q    <= urs_pkg::URS_RST_BYTE;
      res2_q    <= urs_pkg::URS_RST_BYTE;
      pau1_q    <= urs_pkg::URS_RST_BYTE;
      pau2_q    <= urs_pkg::URS_RST_BYTE;
      thr_q     <= urs_pkg::URS_RST_BYTE;
      trg_q     <= urs_pkg::URS_RST_BYTE;
      fifo_en_q <= 1'b0;
      dma_q     <= 1'b0;
      tx_trig_q <= urs_pkg::URS_RST_TRIG;
      rx_trig_q <= urs_pkg::URS_RST_TRIG;
    end else if (wr_fire) begin
      // Read-only selections fall to the default arm and store nothing
      case (cur_reg)
        urs_pkg::R_INT_EN: begin
          ie_q <= enh_en ? wdata : ((ie_q & urs_pkg::URS_IE_ENH_MASK) | (wdata & ~urs_pkg::URS_IE_ENH_MASK));
        end
        urs_pkg::R_INT_SRC: begin
          fifo_en_q <= wdata[urs_pkg::URS_FS_FIFO_EN];
          dma_q     <= wdata[urs_pkg::URS_FS_DMA];
          rx_trig_q <= wdata[7:6];
          if (enh_en) begin
            tx_trig_q <= wdata[5:4];
          end
        end
        urs_pkg::R_LINE_FMT: begin
          lf_q <= wdata;
        end
        urs_pkg::R_MODEM_CTL: begin
          // Bit 7 sits inside the enhanced mask, so one guard covers both cases
          mc_q <= enh_en ? wdata : ((mc_q & urs_pkg::URS_MC_ENH_MASK) | (wdata & ~urs_pkg::URS_MC_ENH_MASK));
        end
        urs_pkg::R_SCRATCH: begin
          scr_q <= wdata;
        end
        urs_pkg::R_DIV_LO: begin
          dlo_q <= wdata;
        end
        urs_pkg::R_DIV_HI: begin
          dhi_q <= wdata;
        end
        urs_pkg::R_ENH: begin
          enh_q <= wdata;
        end
        urs_pkg::R_RESUME1: begin
          res1_q <= wdata;
        end
        urs_pkg::R_RESUME2: begin
          res2_q <= wdata;
        end
        urs_pkg::R_PAUSE1: begin
          pau1_q <= wdata;
        end
        urs_pkg::R_PAUSE2: begin
          pau2_q <= wdata;
        end
        urs_pkg::R_THRESH: begin
          thr_q <= wdata;
        end
        urs_pkg::R_TRIG: begin
          trg_q <= wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit load and FIFO clear pulses
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_data_q <= urs_pkg::URS_RST_BYTE;
      tx_load_q <= 1'b0;
      rx_clr_q  <= 1'b0;
      tx_clr_q  <= 1'b0;
    end else begin
      tx_load_q <= wr_fire && cur_reg == urs_pkg::R_HOLD;
      if (wr_fire && cur_reg == urs_pkg::R_HOLD) begin
        tx_data_q <= wdata;
      end
      // Clear bits never stored, so each write gives a single one-cycle pulse
      rx_clr_q <= wr_fire && cur_reg == urs_pkg::R_INT_SRC && wdata[urs_pkg::URS_FS_RX_CLR];
      tx_clr_q <= wr_fire && cur_reg == urs_pkg::R_INT_SRC && wdata[urs_pkg::URS_FS_TX_CLR];
    end
  end

  // ----------------------------------------------------------------
  // Receive holding in single-byte mode
  // ----------------------------------------------------------------
  // The byte waits for the next baud tick, so a host reading straight after the
  // status report may still see the previous byte.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_q   <= urs_pkg::URS_RST_BYTE;
      pend_v_q <= 1'b0;
      hold_q   <= urs_pkg::URS_RST_BYTE;
    end else if (rx_char_stb && !fifo_en_q) begin
      pend_q   <= rx_char;
      pend_v_q <= 1'b1;
    end else if (pend_v_q && baud_tick) begin
      hold_q   <= pend_q;
      pend_v_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Modem change flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modem_q <= '0;
      delta_q <= '0;
    end else begin
      modem_q <= modem_in;
      // A change in the clearing cycle survives the clear
      delta_q <= ((rd_end && rd_reg_q == urs_pkg::R_MODEM_ST) ? 4'h0 : delta_q) | (modem_q ^ modem_in);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = urs_pkg::URS_RST_BYTE;
    case (rd_act_q ? rd_reg_q : cur_reg)
      urs_pkg::R_HOLD:      rd_mux = fifo_en_q ? rx_head : hold_q;
      urs_pkg::R_INT_EN:    rd_mux = ie_q;
      urs_pkg::R_INT_SRC:   rd_mux = {fifo_en_q, fifo_en_q, enh_en & int_in.flow_flag,
                                      enh_en & int_in.pause_flag, int_in.code, int_in.no_irq};
      urs_pkg::R_LINE_FMT:  rd_mux = lf_q;
      urs_pkg::R_MODEM_CTL: rd_mux = mc_q;
      urs_pkg::R_LINE_ST:   rd_mux = {line_in.fifo_err, line_in.tx_all_empty, line_in.tx_hold_empty,
                                      line_in.brk, line_in.framing_err, line_in.parity_err,
                                      line_in.overrun, line_in.avail};
      urs_pkg::R_MODEM_ST:  rd_mux = {modem_q, delta_q};
      urs_pkg::R_SCRATCH:   rd_mux = scr_q;
      urs_pkg::R_DIV_LO:    rd_mux = dlo_q;
      urs_pkg::R_DIV_HI:    rd_mux = dhi_q;
      urs_pkg::R_ENH:       rd_mux = enh_q;
      urs_pkg::R_RESUME1:   rd_mux = res1_q;
      urs_pkg::R_RESUME2:   rd_mux = res2_q;
      urs_pkg::R_PAUSE1:    rd_mux = pau1_q;
      urs_pkg::R_PAUSE2:    rd_mux = pau2_q;
      urs_pkg::R_THRESH:    rd_mux = thr_q;
      urs_pkg::R_TRIG:      rd_mux = trg_q;
      urs_pkg::R_READY:     rd_mux = {2'h0, ready_in[3:2], 2'h0, ready_in[1:0]};
      default:              rd_mux = urs_pkg::URS_RST_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q  <= urs_pkg::URS_RST_BYTE;
      rx_pop_q <= 1'b0;
    end else begin
      rdata_q  <= rd_mux;
      rx_pop_q <= rd_end && rd_reg_q == urs_pkg::R_HOLD;
    end
  end

  assign rdata       = rdata_q;
  assign rdata_oe    = rd_act_q && !rd_n;
  assign rx_pop      = rx_pop_q;
  assign rx_fifo_clr = rx_clr_q;
  assign tx_fifo_clr = tx_clr_q;
  assign tx_data     = tx_data_q;
  assign tx_load     = tx_load_q;
  assign cfg         = '{divisor: {dhi_q, dlo_q}, line_format: lf_q, interrupt_enables: ie_q,
                         modem_control_bits: mc_q, enhanced_features: enh_q, fifo_en: fifo_en_q,
                         dma_mode: dma_q, tx_trig: tx_trig_q, rx_trig: rx_trig_q, flow_thresholds: thr_q,
                         fifo_trigger_levels: trg_q, resume_char_one: res1_q, resume_char_two: res2_q,
                         pause_char_one: pau1_q, pause_char_two: pau2_q};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  fifo_clr_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_fire && cur_reg == urs_pkg::R_INT_SRC && wdata[urs_pkg::URS_FS_RX_CLR]) |=> rx_fifo_clr ##1 !rx_fifo_clr)
    else $error("receive clear not a single pulse");

  clk_sel_guard_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_fire && cur_reg == urs_pkg::R_MODEM_CTL && !enh_en) |=> $stable(mc_q[7]))
    else $error("clock select changed without enhanced enable");

  inten_hi_guard_a: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(enh_en) |-> $stable(ie_q[7:4]) && $stable(tx_trig_q) && $stable(mc_q[6:5]))
    else $error("enhanced bit changed while disabled");

  read_only_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_fire && (cur_reg == urs_pkg::R_LINE_ST || cur_reg == urs_pkg::R_MODEM_ST ||
                 cur_reg == urs_pkg::R_READY)) |=> $stable(cfg) && $stable(scr_q))
    else $error("read-only write changed state");

  divisor_route_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_fire && addr == urs_pkg::URS_A_HOLD && lf_q[urs_pkg::URS_LF_DIV]) |=> !tx_load && cfg.divisor[7:0] == $past(wdata))
    else $error("divisor access did not reach divisor");

  tx_hold_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_fire && addr == urs_pkg::URS_A_HOLD && !lf_q[urs_pkg::URS_LF_DIV]) |=> tx_load && tx_data == $past(wdata))
    else $error("transmit byte not loaded");

  key_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(enh_q) || $changed(res1_q) || $changed(pau2_q) |-> $past(lf_q) == urs_pkg::URS_LF_KEY)
    else $error("flow register changed without key");

  thresh_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(thr_q) || $changed(trg_q) |-> $past(enh_en) && $past(mc_q[urs_pkg::URS_MC_THR_EN]))
    else $error("threshold register changed without gates");

  rx_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rx_char_stb && !fifo_en_q) ##1 (!baud_tick && !rx_char_stb) |=> $stable(hold_q))
    else $error("holding byte updated before baud tick");

  src_fifo_bits_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!rd_act_q && cur_reg == urs_pkg::R_INT_SRC) |=> rdata[7:6] == {2{$past(fifo_en_q)}})
    else $error("source bits 7:6 do not follow FIFO enable");

endmodule // urs_top

// ---- tb/urs_host_model.sv ----
// Host processor model: register cycles on the parallel bus
`timescale 1ns/1ps
module urs_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Parallel bus
  output logic            channel_a_select_n,
  output logic            channel_b_select_n,
  output logic [2:0]      addr,
  output logic            rd_n,
  output logic            wr_n,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rdata_oe
);
  initial begin
    channel_a_select_n = 1'b1;
    channel_b_select_n = 1'b1;
    addr = 3'h0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    wdata = 8'h00;
  end

  // Strobe two edges wide; released lines carry the inverse, never a stale value
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #2;
    channel_a_select_n = 1'b0;
    addr = a;
    wdata = d;
    wr_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #2;
    wr_n = 1'b1;
    channel_a_select_n = 1'b1;
    addr = ~a;
    wdata = ~d;
  endtask

  // Data and enable taken just after the third edge, once settled, then the strobe is released
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic oe);
    @(posedge sys_clk);
    #2;
    channel_a_select_n = 1'b0;
    addr = a;
    rd_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #2;
    d = rdata;
    oe = rdata_oe;
    rd_n = 1'b1;
    channel_a_select_n = 1'b1;
    addr = ~a;
  endtask
endmodule // urs_host_model

// ---- tb/tb_top.sv ----
// Self-checking bench for register selection of one serial channel
`timescale 1ns/1ps
module tb_top;
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  baud_tick = 1'b0;
  logic                  rx_char_stb = 1'b0;
  logic [7:0]            rx_char = 8'h00;
  logic [7:0]            rx_head = 8'h00;
  logic [3:0]            ready_in = 4'h0;
  logic [3:0]            bcnt = 4'h0;
  urs_pkg::urs_line_in_t line_in = '0;
  urs_pkg::urs_modem_t   modem_in = '0;
  urs_pkg::urs_int_in_t  int_in = '0;
  urs_pkg::urs_cfg_t     cfg, c0;
  logic                  channel_a_select_n, channel_b_select_n, rd_n, wr_n, rdata_oe;
  logic                  rx_pop, rx_fifo_clr, tx_load, tx_fifo_clr;
  logic [2:0]            addr;
  logic [7:0]            wdata, rdata, tx_data, m, s, x [8];
  logic [7:0]            txq [$];
  int                    failures = 0;
  int                    comparisons = 0;
  int                    n_clr = 0;
  int                    n_pop = 0;

  urs_host_model u_urs_host_model (.sys_clk, .channel_a_select_n, .channel_b_select_n, .addr, .rd_n, .wr_n,
                                   .wdata, .rdata, .rdata_oe);
  urs_top u_urs_top (.sys_clk, .rst, .channel_a_select_n, .channel_b_select_n, .addr, .rd_n, .wr_n, .wdata,
                     .rdata, .rdata_oe, .baud_tick, .rx_char_stb, .rx_char, .rx_head, .rx_pop, .rx_fifo_clr,
                     .tx_data, .tx_load, .tx_fifo_clr, .line_in, .modem_in, .int_in, .ready_in, .cfg);

  always #25 sys_clk = ~sys_clk;

  // Free-running tick, one cycle in sixteen
  always @(posedge sys_clk) begin
    #2;
    bcnt = bcnt + 4'h1;
    baud_tick = (bcnt == 4'h0);
  end

  always @(posedge sys_clk) begin
    if (tx_load === 1'b1) chk({8'h00, tx_data}, (txq.size() > 0) ? {8'h00, txq.pop_front()} : 16'hffff);
    if (rx_fifo_clr === 1'b1) n_clr++;
    if (tx_fifo_clr === 1'b1) n_clr++;
    if (rx_pop === 1'b1) n_pop++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_urs_host_model.wr(a, d);
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       o;
    u_urs_host_model.rd(a, d, o);
    chk({8'h00, d}, {8'h00, exp});
    chk({15'h0000, o}, 16'h0001);
  endtask

  task automatic wrc(input logic [2:0] a, input logic [7:0] d, input logic [7:0] exp);
    wr(a, d);
    rdc(a, exp);
  endtask

  task automatic tdone(input string name);
    $display("test %s done, %0d mismatches so far", name, failures);
  endtask

  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h201e4444));
    repeat (2) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    for (int a = 1; a < 8; a++) if (a inside {1, 3, 4, 7}) rdc(3'(a), 8'h00);
    s = 8'($urandom);
    wrc(3'h7, s, s);
    m = 8'($urandom) & 8'h7f;
    wrc(3'h3, m, m);
    wr(3'h3, 8'h00);
    m = 8'($urandom);
    wrc(3'h1, m, m & 8'h0f);
    m = 8'($urandom);
    wrc(3'h4, m, m & 8'h1f);
    tdone("plain");
    line_in = 8'($urandom);
    m = {<<{line_in}};
    rdc(3'h5, m);
    rdc(3'h6, {modem_in, 4'h0});
    modem_in = 4'($urandom) | 4'h1;
    rdc(3'h6, {modem_in, modem_in});
    rdc(3'h6, {modem_in, 4'h0});
    c0 = cfg;
    wr(3'h5, 8'hff);
    wr(3'h6, 8'hff);
    chk(16'(cfg === c0), 16'h0001);
    tdone("status");
    wr(3'h4, 8'h04);
    ready_in = 4'($urandom);
    u_urs_host_model.channel_b_select_n = 1'b0;
    rdc(3'h7, {2'b00, ready_in[3:2], 2'b00, ready_in[1:0]});
    wr(3'h7, ~s);
    wr(3'h4, 8'h14);
    rdc(3'h7, s);
    u_urs_host_model.channel_b_select_n = 1'b1;
    rx_char = 8'($urandom);
    @(posedge sys_clk);
    #2 rx_char_stb = 1'b1;
    @(posedge sys_clk);
    #2 rx_char_stb = 1'b0;
    repeat (17) @(posedge sys_clk);
    rdc(3'h0, rx_char);
    m = 8'($urandom);
    txq.push_back(m);
    wr(3'h0, m);
    tdone("holding and ready");
    wr(3'h3, 8'h80);
    m = 8'($urandom);
    wrc(3'h0, m, m);
    wrc(3'h1, ~m, ~m);
    chk(cfg.divisor, {~m, m});
    chk(16'(txq.size()), 16'h0000);
    wr(3'h3, 8'hbf);
    m = 8'($urandom) | 8'h10;
    wrc(3'h2, m, m);
    for (int a = 4; a < 8; a++) begin
      x[a] = 8'($urandom);
      wrc(3'(a), x[a], x[a]);
    end
    chk({cfg.resume_char_one, cfg.pause_char_two}, {x[4], x[7]});
    chk({cfg.enhanced_features, cfg.pause_char_one}, {m, x[6]});
    tdone("divisor and key");
    wr(3'h3, 8'h00);
    m = 8'($urandom);
    wrc(3'h1, m, m);
    m = 8'($urandom) | 8'h40;
    wrc(3'h4, m, m);
    x[0] = 8'($urandom);
    x[1] = 8'($urandom);
    wrc(3'h6, x[0], x[0]);
    wrc(3'h7, x[1], x[1]);
    chk({cfg.flow_thresholds, cfg.fifo_trigger_levels}, {x[0], x[1]});
    wr(3'h4, 8'h00);
    rdc(3'h7, s);
    int_in = 6'($urandom);
    m = 8'($urandom) | 8'h07;
    wr(3'h2, m);
    @(posedge sys_clk);
    chk(16'(n_clr), 16'h0002);
    chk({10'h000, cfg.rx_trig, cfg.tx_trig, cfg.dma_mode, cfg.fifo_en}, {10'h000, m[7:3], 1'b1});
    rdc(3'h2, {2'b11, int_in.flow_flag, int_in.pause_flag, int_in.code, int_in.no_irq});
    rx_head = 8'($urandom);
    rdc(3'h0, rx_head);
    repeat (3) @(posedge sys_clk);
    chk(16'(n_pop), 16'h0002);
    tdone("enhanced and fifo");
    end_sim();
  end

  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule // tb_top
